//--- pkg/spce_pkg.sv
// constants shared by the servo command and emergency logic
package spce_pkg;
	// object indices
	localparam logic [15:0] OBJ_CMD_WORD   = 16'h6040;
	localparam logic [15:0] OBJ_STATUS     = 16'h6041;
	localparam logic [15:0] OBJ_MODES_OP   = 16'h6060;
	localparam logic [15:0] OBJ_STD_FAULT  = 16'h603F;
	localparam logic [15:0] OBJ_MFR_FAULT  = 16'h213F;
	localparam logic [15:0] OBJ_ERR_REG    = 16'h1001;
	// command word bit positions
	localparam int CW_SWITCH_ON  = 0;
	localparam int CW_EN_VOLT    = 1;
	localparam int CW_QSTOP_N    = 2;
	localparam int CW_OP_EN      = 3;
	localparam int CW_NEW_POINT  = 4;
	localparam int CW_IMMEDIATE  = 5;
	localparam int CW_RELATIVE   = 6;
	localparam int CW_FAULT_RST  = 7;
	localparam int CW_PAUSE      = 8;
	// status word bit positions
	localparam int SW_OP_ENABLED = 2;
	localparam int SW_QSTOP_N    = 5;
	localparam int SW_TARGET     = 10;
	localparam int SW_NO_ACCEPT  = 12;
	// reset values
	localparam logic [15:0] CMD_WORD_RST  = 16'h0000;
	localparam logic [3:0]  OP_MODE_RST   = 4'h7;
	localparam logic [6:0]  STATION_RST   = 7'h01;
	localparam logic [2:0]  BIT_RATE_RST  = 3'h5;
	// legal operating modes
	localparam logic [3:0]  OP_MODE_POS   = 4'h0;
	localparam logic [3:0]  OP_MODE_SPD   = 4'h1;
	localparam logic [3:0]  OP_MODE_TRQ   = 4'h2;
	localparam logic [3:0]  OP_MODE_BUS   = 4'h7;
	// station limits
	localparam logic [6:0]  STATION_MIN   = 7'h01;
	localparam logic [6:0]  STATION_MAX   = 7'h7F;
	// modes-of-operation value for profile position
	localparam logic [7:0]  PROFILE_POS   = 8'h01;
	// emergency frame identifier base
	localparam logic [10:0] EMCY_ID_BASE  = 11'h080;
	// bit rate code to kbit/s
	function automatic logic [10:0] spce_rate_kbps(input logic [2:0] code);
		unique case (code)
			3'h0: spce_rate_kbps = 11'h014;
			3'h1: spce_rate_kbps = 11'h032;
			3'h2: spce_rate_kbps = 11'h064;
			3'h3: spce_rate_kbps = 11'h07D;
			3'h4: spce_rate_kbps = 11'h0FA;
			3'h5: spce_rate_kbps = 11'h1F4;
			3'h6: spce_rate_kbps = 11'h320;
			3'h7: spce_rate_kbps = 11'h3E8;
		endcase
	endfunction
endpackage

//--- pkg/spce_emcy_if.sv
// fault event carrier between command logic and emergency producer
`timescale 1ns/1ps
interface spce_emcy_if;
	logic        event_p;
	logic [15:0] std_code;
	logic [15:0] mfr_code;
	logic [7:0]  err_reg;
	logic [6:0]  node_id;
	modport src  (output event_p, std_code, mfr_code, err_reg, node_id);
	modport prod (input  event_p, std_code, mfr_code, err_reg, node_id);
endinterface

//--- core/spce_emcy.sv
// emergency frame producer and fault code objects
`timescale 1ns/1ps
module spce_emcy
	import spce_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	spce_emcy_if.prod        ev,
	output logic             emcy_valid,
	input  wire logic        emcy_ready,
	output logic [10:0]      emcy_id,
	output logic [63:0]      emcy_data,
	output logic [15:0]      std_fault_obj,
	output logic [15:0]      mfr_fault_obj
);
	logic pending;
	wire  sent = emcy_valid && emcy_ready;

	// one frame per event while none is pending; a new event wins over the send
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else begin
			pending <= ev.event_p | (pending & ~sent);
		end
	end
	assign emcy_valid = pending;

	// frame contents and fault objects captured per event
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			emcy_id       <= EMCY_ID_BASE;
			emcy_data     <= 64'h0000_0000_0000_0000;
			std_fault_obj <= 16'h0000;
			mfr_fault_obj <= 16'h0000;
		end else if (ev.event_p) begin
			emcy_id       <= EMCY_ID_BASE + {4'h0, ev.node_id};
			emcy_data     <= {24'h00_0000, ev.mfr_code, ev.err_reg,
				ev.std_code};
			std_fault_obj <= ev.std_code;
			mfr_fault_obj <= ev.mfr_code;
		end
	end

	// frame checks
	a_emcy_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
		sent && !ev.event_p |=> !emcy_valid)
		else $error("second emergency frame without new event");
	a_emcy_on_event: assert property (@(posedge clk) disable iff (!rst_n)
		ev.event_p |=> emcy_valid && emcy_data[15:0] == $past(ev.std_code))
		else $error("event gave no emergency frame");
	a_emcy_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		emcy_valid |-> emcy_data[63:40] == 24'h00_0000)
		else $error("reserved emergency bytes not zero");
	a_emcy_ident: assert property (@(posedge clk) disable iff (!rst_n)
		ev.event_p |=> emcy_id == EMCY_ID_BASE + $past(ev.node_id))
		else $error("emergency identifier wrong");
	c_emcy_sent: cover property (@(posedge clk) disable iff (!rst_n)
		ev.event_p ##[1:4] sent);
endmodule

//--- core/spce_top.sv
// profile position command decoder with emergency reporting
`timescale 1ns/1ps
module spce_top
	import spce_pkg::*;
#(
	parameter int POS_W = 32,
	parameter int SPD_W = 32
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	// command word and mode objects
	input  wire logic             cmd_wr,
	input  wire logic [15:0]      cmd_wdata,
	output logic      [15:0]      drive_command_word,
	input  wire logic             modes_op_wr,
	input  wire logic [7:0]       modes_op_wdata,
	output logic      [15:0]      status_word,
	// configuration parameters
	input  wire logic             op_mode_wr,
	input  wire logic [3:0]       op_mode_wdata,
	output logic      [3:0]       operating_mode_param,
	input  wire logic             station_wr,
	input  wire logic [6:0]       station_wdata,
	output logic      [6:0]       station_number_param,
	input  wire logic             bit_rate_wr,
	input  wire logic [2:0]       bit_rate_wdata,
	output logic      [2:0]       bit_rate_param,
	output logic      [10:0]      bit_rate_kbps,
	// positioning parameter objects
	input  wire logic [POS_W-1:0] set_target,
	input  wire logic [SPD_W-1:0] set_start_speed,
	input  wire logic [SPD_W-1:0] set_run_speed,
	input  wire logic [SPD_W-1:0] set_accel,
	input  wire logic [SPD_W-1:0] set_decel,
	// trajectory side
	input  wire logic             move_busy,
	input  wire logic             target_reached,
	input  wire logic             speed_zero,
	output logic                  move_start,
	output logic                  move_abort,
	output logic      [POS_W-1:0] move_target,
	output logic      [SPD_W-1:0] move_start_speed,
	output logic      [SPD_W-1:0] move_run_speed,
	output logic      [SPD_W-1:0] move_accel,
	output logic      [SPD_W-1:0] move_decel,
	output logic                  move_relative,
	output logic                  servo_enable,
	output logic                  quick_stop,
	output logic                  pause,
	output logic                  fault_reset,
	// fault side
	input  wire logic             fault_event,
	input  wire logic [15:0]      fault_std_code,
	input  wire logic [15:0]      fault_mfr_code,
	input  wire logic [7:0]       error_register,
	input  wire logic             fault_active,
	output logic                  emcy_valid,
	input  wire logic             emcy_ready,
	output logic      [10:0]      emcy_id,
	output logic      [63:0]      emcy_data,
	output logic      [15:0]      std_fault_obj,
	output logic      [15:0]      mfr_fault_obj
);
	logic       rst_s1;
	logic       rst_n;
	logic [8:0] act_cmd;
	logic [7:0] modes_op;
	logic       q_full;
	logic [POS_W-1:0] q_target;
	logic [SPD_W-1:0] q_start;
	logic [SPD_W-1:0] q_run;
	logic [SPD_W-1:0] q_acc;
	logic [SPD_W-1:0] q_dec;
	logic       q_rel;

	// reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// edge and freeze decode against the held word
	wire reset_held = cmd_wdata[CW_FAULT_RST];
	wire rst_edge   = cmd_wr && reset_held &&
		!drive_command_word[CW_FAULT_RST];
	wire load_edge  = cmd_wr && !reset_held && cmd_wdata[CW_NEW_POINT] &&
		!drive_command_word[CW_NEW_POINT];
	wire pp_mode    = modes_op == PROFILE_POS;
	wire op_enabled = &act_cmd[CW_OP_EN:CW_SWITCH_ON] && !fault_active;
	wire load_ok    = load_edge && op_enabled && pp_mode;
	wire immediate  = cmd_wdata[CW_IMMEDIATE];
	wire go_now     = load_ok && (immediate || (!move_busy && !q_full));
	wire go_queue   = load_ok && !go_now && !q_full;
	wire go_pending = !load_ok && q_full && !move_busy && !pause &&
		op_enabled && !move_start;
	wire op_mode_ok = op_mode_wdata == OP_MODE_POS ||
		op_mode_wdata == OP_MODE_SPD || op_mode_wdata == OP_MODE_TRQ ||
		op_mode_wdata == OP_MODE_BUS;
	wire station_ok = station_wdata >= STATION_MIN &&
		station_wdata <= STATION_MAX;

	// command word storage; bits 9 upward carry no function
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_command_word <= CMD_WORD_RST;
			act_cmd            <= CMD_WORD_RST[8:0];
			modes_op           <= 8'h00;
		end else begin
			if (cmd_wr) drive_command_word <= cmd_wdata;
			if (cmd_wr && !reset_held) act_cmd <= cmd_wdata[8:0];
			if (modes_op_wr) modes_op <= modes_op_wdata;
		end
	end

	// drive level controls
	assign servo_enable = op_enabled;
	assign quick_stop   = !act_cmd[CW_QSTOP_N];
	assign pause        = act_cmd[CW_PAUSE];

	// one reset pulse per rising edge of the reset bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) fault_reset <= 1'b0;
		else        fault_reset <= rst_edge;
	end

	// configuration parameters keep old value on illegal write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			operating_mode_param <= OP_MODE_RST;
			station_number_param <= STATION_RST;
			bit_rate_param       <= BIT_RATE_RST;
		end else begin
			if (op_mode_wr && op_mode_ok)
				operating_mode_param <= op_mode_wdata;
			if (station_wr && station_ok)
				station_number_param <= station_wdata;
			if (bit_rate_wr) bit_rate_param <= bit_rate_wdata;
		end
	end
	assign bit_rate_kbps = spce_rate_kbps(bit_rate_param);

	// single waiting instruction slot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_full   <= 1'b0;
			q_target <= '0;
			q_start  <= '0;
			q_run    <= '0;
			q_acc    <= '0;
			q_dec    <= '0;
			q_rel    <= 1'b0;
		end else if (go_queue) begin
			q_full   <= 1'b1;
			q_target <= set_target;
			q_start  <= set_start_speed;
			q_run    <= set_run_speed;
			q_acc    <= set_accel;
			q_dec    <= set_decel;
			q_rel    <= cmd_wdata[CW_RELATIVE];
		end else if (go_pending || (go_now && immediate)) begin
			q_full   <= 1'b0;
		end
	end

	// instruction issue to the trajectory side
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			move_start       <= 1'b0;
			move_abort       <= 1'b0;
			move_target      <= '0;
			move_start_speed <= '0;
			move_run_speed   <= '0;
			move_accel       <= '0;
			move_decel       <= '0;
			move_relative    <= 1'b0;
		end else begin
			move_start <= go_now || go_pending;
			move_abort <= go_now && move_busy;
			if (go_now) begin
				move_target      <= set_target;
				move_start_speed <= set_start_speed;
				move_run_speed   <= set_run_speed;
				move_accel       <= set_accel;
				move_decel       <= set_decel;
				move_relative    <= cmd_wdata[CW_RELATIVE];
			end else if (go_pending) begin
				move_target      <= q_target;
				move_start_speed <= q_start;
				move_run_speed   <= q_run;
				move_accel       <= q_acc;
				move_decel       <= q_dec;
				move_relative    <= q_rel;
			end
		end
	end

	// status word: handshake and arrival bits
	always_comb begin
		status_word                = 16'h0000;
		status_word[SW_OP_ENABLED] = op_enabled;
		status_word[3]             = fault_active;
		status_word[SW_QSTOP_N]    = act_cmd[CW_QSTOP_N];
		status_word[SW_TARGET]     = pause ? speed_zero : target_reached;
		status_word[SW_NO_ACCEPT]  = q_full;
	end

	// fault events to the emergency producer
	spce_emcy_if emcy_bus ();
	assign emcy_bus.event_p  = fault_event;
	assign emcy_bus.std_code = fault_std_code;
	assign emcy_bus.mfr_code = fault_mfr_code;
	assign emcy_bus.err_reg  = error_register;
	assign emcy_bus.node_id  = station_number_param;

	spce_emcy u_emcy (
		.clk           (clk),
		.rst_n         (rst_n),
		.ev            (emcy_bus),
		.emcy_valid    (emcy_valid),
		.emcy_ready    (emcy_ready),
		.emcy_id       (emcy_id),
		.emcy_data     (emcy_data),
		.std_fault_obj (std_fault_obj),
		.mfr_fault_obj (mfr_fault_obj)
	);

	// command decode checks
	a_quick_stop_lvl: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_wr && !cmd_wdata[CW_FAULT_RST] |=>
		quick_stop == !$past(cmd_wdata[CW_QSTOP_N]))
		else $error("quick stop does not follow bit 2");
	a_reset_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		fault_reset |=> !fault_reset)
		else $error("fault reset longer than one cycle");
	a_reset_on_edge: assert property (@(posedge clk) disable iff (!rst_n)
		rst_edge |=> fault_reset)
		else $error("missing fault reset pulse");
	a_freeze_held: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_wr && cmd_wdata[CW_FAULT_RST] |=> $stable(act_cmd))
		else $error("command acted while reset bit high");
	a_load_gate: assert property (@(posedge clk) disable iff (!rst_n)
		move_start && !$past(go_pending) |->
		$past(op_enabled) && $past(pp_mode))
		else $error("instruction latched outside enabled pp mode");
	a_immediate_abort: assert property (@(posedge clk) disable iff (!rst_n)
		load_ok && immediate && move_busy |=> move_abort && move_start)
		else $error("immediate update did not abort");
	a_busy_flag: assert property (@(posedge clk) disable iff (!rst_n)
		go_queue |=> status_word[SW_NO_ACCEPT])
		else $error("status bit 12 low with queued instruction");
	a_station_range: assert property (@(posedge clk) disable iff (!rst_n)
		station_number_param != 7'h00)
		else $error("station number out of range");
	c_queued_move: cover property (@(posedge clk) disable iff (!rst_n)
		go_queue ##[1:50] go_pending);
	c_abort_move: cover property (@(posedge clk) disable iff (!rst_n)
		move_abort);
	c_reset_pulse: cover property (@(posedge clk) disable iff (!rst_n)
		fault_reset);
endmodule

//--- testbench/spce_host.sv
// host controller model: command object writes and frame acceptance
`timescale 1ns/1ps
module spce_host
	import spce_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        emcy_valid,
	output logic             cmd_wr,
	output logic [15:0]      cmd_wdata,
	output logic             modes_op_wr,
	output logic [7:0]       modes_op_wdata,
	output logic             emcy_ready
);
	int lat = 0;
	int cnt = 0;
	// idle bus, no frame taken yet
	initial begin
		cmd_wr = 1'b0;
		cmd_wdata = 16'h0000;
		modes_op_wr = 1'b0;
		modes_op_wdata = 8'h00;
		emcy_ready = 1'b0;
	end
	// take a pending frame after lat cycles, prompt or slow
	always @(negedge clk) begin
		cnt <= emcy_valid ? cnt + 1 : 0;
		emcy_ready <= emcy_valid && (cnt >= lat);
	end
	// one command word write, data scrambled once released
	task automatic put_cmd(input logic [15:0] v);
		@(negedge clk);
		cmd_wr = 1'b1;
		cmd_wdata = v;
		@(negedge clk);
		cmd_wr = 1'b0;
		cmd_wdata = ~v;
	endtask
	// one modes-of-operation write
	task automatic put_mode(input logic [7:0] v);
		@(negedge clk);
		modes_op_wr = 1'b1;
		modes_op_wdata = v;
		@(negedge clk);
		modes_op_wr = 1'b0;
		modes_op_wdata = ~v;
	endtask
	// select profile position, then hold the enable bits high
	task automatic enable();
		put_mode(PROFILE_POS);
		put_cmd(16'h000F);
	endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the command decoder and emergency producer
`timescale 1ns/1ps
module tb;
	import spce_pkg::*;
	logic        clk, arst_n, op_mode_wr, station_wr, bit_rate_wr;
	logic        cmd_wr, modes_op_wr, emcy_ready, emcy_valid, pause;
	logic        move_busy, target_reached, speed_zero, fault_event;
	logic        fault_active, move_start, move_abort, move_relative;
	logic        servo_enable, quick_stop, fault_reset;
	logic [15:0] cmd_wdata, drive_command_word, status_word;
	logic [15:0] fault_std_code, fault_mfr_code, std_fault_obj, mfr_fault_obj;
	logic [7:0]  modes_op_wdata, error_register;
	logic [3:0]  op_mode_wdata, operating_mode_param;
	logic [6:0]  station_wdata, station_number_param, st;
	logic [2:0]  bit_rate_wdata, bit_rate_param;
	logic [10:0] bit_rate_kbps, emcy_id;
	logic [63:0] emcy_data;
	logic [31:0] set_target, set_start_speed, set_run_speed, set_accel;
	logic [31:0] set_decel, move_target, move_start_speed, move_run_speed;
	logic [31:0] move_accel, move_decel, old;
	logic [3:0]  em;
	logic [2:0]  eb;
	logic [6:0]  v7;
	logic [15:0] cw;
	logic        ev_q = 1'b0;
	int          errors = 0, total_checks = 0, seed = 80, i, k, s0, a0, r0, e0;
	int          n_start = 0, n_abort = 0, n_frst = 0, n_emcy = 0;

	spce_top i_dut (.clk, .arst_n, .cmd_wr, .cmd_wdata, .drive_command_word,
		.modes_op_wr, .modes_op_wdata, .status_word, .op_mode_wr,
		.op_mode_wdata, .operating_mode_param, .station_wr, .station_wdata,
		.station_number_param, .bit_rate_wr, .bit_rate_wdata, .bit_rate_param,
		.bit_rate_kbps, .set_target, .set_start_speed, .set_run_speed,
		.set_accel, .set_decel, .move_busy, .target_reached, .speed_zero,
		.move_start, .move_abort, .move_target, .move_start_speed,
		.move_run_speed, .move_accel, .move_decel, .move_relative,
		.servo_enable, .quick_stop, .pause, .fault_reset, .fault_event,
		.fault_std_code, .fault_mfr_code, .error_register, .fault_active,
		.emcy_valid, .emcy_ready, .emcy_id, .emcy_data, .std_fault_obj,
		.mfr_fault_obj);
	spce_host i_host (.clk, .emcy_valid, .cmd_wr, .cmd_wdata, .modes_op_wr,
		.modes_op_wdata, .emcy_ready);

	// clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// pulse and frame counters
	always @(posedge clk) begin
		n_start <= n_start + int'(move_start === 1'b1);
		n_abort <= n_abort + int'(move_abort === 1'b1);
		n_frst <= n_frst + int'(fault_reset === 1'b1);
		n_emcy <= n_emcy + int'(emcy_valid === 1'b1 && !ev_q);
		ev_q <= (emcy_valid === 1'b1);
	end

	function automatic logic [10:0] exp_kbps(input int c);
		int t[8] = '{20, 50, 100, 125, 250, 500, 800, 1000};
		return 11'(t[c]);
	endfunction
	task automatic check(input logic [63:0] seen, exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t %s", $time, what);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// one configuration write: 0 mode, 1 station, 2 bit rate
	task automatic cfg(input int w, input logic [6:0] v);
		@(negedge clk);
		{op_mode_wr, station_wr, bit_rate_wr} = 3'b100 >> w;
		{op_mode_wdata, station_wdata, bit_rate_wdata} = {v[3:0], v, v[2:0]};
		@(negedge clk);
		{op_mode_wr, station_wr, bit_rate_wr} = 3'b000;
	endtask
	task automatic new_set();
		{set_target, set_start_speed} = {$random(seed), $random(seed)};
		{set_run_speed, set_accel} = {$random(seed), $random(seed)};
		set_decel = $random(seed);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#50000;
		errors++;
		end_of_test();
	end

	initial begin
		{arst_n, op_mode_wr, station_wr, bit_rate_wr, fault_event} = 5'b00000;
		{op_mode_wdata, station_wdata, bit_rate_wdata} = 14'h0000;
		{move_busy, target_reached, speed_zero, fault_active} = 4'b0000;
		{fault_std_code, fault_mfr_code, error_register} = 40'h0;
		new_set();
		repeat (8) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		tick(4);
		// reset values and configuration
		check(operating_mode_param, OP_MODE_RST, "mode reset");
		check(station_number_param, STATION_RST, "station reset");
		check(bit_rate_kbps, exp_kbps(5), "rate reset");
		em = 4'h7;
		for (i = 0; i < 16; i++) begin
			cfg(0, 7'(i));
			if (i inside {0, 1, 2, 7})
				em = 4'(i);
			check(operating_mode_param, em, "mode write");
		end
		for (i = 0; i < 8; i++) begin
			cfg(2, 7'(i));
			check(bit_rate_kbps, exp_kbps(i), "rate decode");
		end
		cfg(1, 7'h7F);
		cfg(1, 7'h00);
		check(station_number_param, 7'h7F, "station range");
		st = 7'($unsigned($random(seed)) % 127 + 1);
		cfg(1, st);
		check(station_number_param, st, "station write");
		// random configuration writes against a model of the parameters
		eb = 3'h7;
		for (i = 0; i < 24; i++) begin
			k = $unsigned($random(seed)) % 3;
			v7 = 7'($random(seed));
			cfg(k, v7);
			if (k == 0 && v7[3:0] inside {0, 1, 2, 7})
				em = v7[3:0];
			if (k == 1 && v7 != 7'h00)
				st = v7;
			if (k == 2)
				eb = v7[2:0];
			check({operating_mode_param, station_number_param,
				bit_rate_param}, {em, st, eb}, "cfg");
		end
		// loads refused outside profile position, then accepted
		move_busy = 1'($random(seed));
		i_host.put_mode(8'($random(seed)) | 8'h02);
		i_host.put_cmd(16'h000F);
		s0 = n_start;
		i_host.put_cmd(16'h001F);
		tick(4);
		check(64'(n_start - s0), 0, "load without mode");
		move_busy = 1'b0;
		i_host.enable();
		tick(2);
		check(servo_enable, 1'b1, "enable");
		for (k = 0; k < 4; k++) begin
			new_set();
			i_host.put_cmd(16'h000F | 16'(k[0]) << 6);
			s0 = n_start;
			i_host.put_cmd(16'h001F | 16'(k[0]) << 6);
			i_host.put_cmd(16'h001F | 16'(k[0]) << 6);
			tick(3);
			check(64'(n_start - s0), 1, "one load per edge");
			check({move_target, move_start_speed}, {set_target, set_start_speed},
				"load pos");
			check({move_run_speed, move_accel}, {set_run_speed, set_accel},
				"load spd");
			check(move_decel, set_decel, "load dec");
			check(move_relative, k[0], "relative");
		end
		// queued load waits for the current move
		move_busy = 1'b1;
		i_host.put_cmd(16'h000F);
		s0 = n_start;
		i_host.put_cmd(16'h001F);
		tick(3);
		check(status_word[SW_NO_ACCEPT], 1'b1, "slot full");
		check(64'(n_start - s0), 0, "queued waits");
		old = set_target;
		new_set();
		move_busy = 1'b0;
		tick(4);
		check(64'(n_start - s0), 1, "queued runs");
		check(move_target, old, "queued values");
		check(status_word[SW_NO_ACCEPT], 1'b0, "slot free");
		// immediate load aborts a busy move
		move_busy = 1'b1;
		i_host.put_cmd(16'h000F);
		{s0, a0} = {n_start, n_abort};
		i_host.put_cmd(16'h003F);
		tick(3);
		check(64'({n_start - s0, n_abort - a0}), {32'd1, 32'd1}, "abort");
		move_busy = 1'b0;
		// quick stop, pause and ignored bits
		i_host.put_cmd(16'h000B);
		check({quick_stop, status_word[SW_QSTOP_N]}, 2'b10, "qstop");
		{target_reached, speed_zero} = 2'($random(seed));
		i_host.put_cmd(16'h010F);
		check({pause, status_word[SW_TARGET]}, {1'b1, speed_zero},
			"pause");
		i_host.put_cmd(16'h000F);
		check({pause, status_word[SW_TARGET]}, {1'b0, target_reached},
			"run");
		cw = {7'($random(seed)), 9'h00F};
		i_host.put_cmd(cw);
		check(drive_command_word, cw, "stored word");
		check({servo_enable, quick_stop, pause}, 3'b100, "spare");
		// fault reset once per edge, other commands frozen
		r0 = n_frst;
		s0 = n_start;
		i_host.put_cmd(16'h008F);
		i_host.put_cmd(16'h0097);
		i_host.put_cmd(16'h009F);
		tick(3);
		check(64'(n_frst - r0), 1, "one reset");
		check({servo_enable, 31'(n_start - s0)}, 32'h8000_0000, "freeze");
		i_host.put_cmd(16'h000F);
		i_host.put_cmd(16'h0080);
		tick(3);
		check(64'(n_frst - r0), 2, "second reset");
		// emergency frames, prompt and slow, single and merged events
		for (k = 0; k < 3; k++) begin
			fault_active = 1'($random(seed));
			i_host.lat = k * 4;
			e0 = n_emcy;
			for (i = 0; i <= k / 2; i++) begin
				@(negedge clk);
				fault_event = 1'b1;
				{fault_std_code, fault_mfr_code} = $random(seed);
				error_register = 8'($random(seed));
				@(negedge clk);
				fault_event = 1'b0;
			end
			check(status_word[3:2], {fault_active, !fault_active},
				"fault bit");
			check(emcy_id, EMCY_ID_BASE + 11'(st), "frame id");
			check(emcy_data, {24'h00_0000, fault_mfr_code, error_register,
				fault_std_code}, "frame data");
			check({std_fault_obj, mfr_fault_obj},
				{fault_std_code, fault_mfr_code}, "fault objects");
			for (i = 0; i < 30 && emcy_valid === 1'b1; i++)
				tick(1);
			tick(6);
			check(64'(n_emcy - e0), 1, "one frame");
		end
		fault_active = 1'b0;
		end_of_test();
	end
endmodule
